// [core/fsl_pkg.sv]
// constants for the fault status latch block
package fsl_pkg;

  // register byte offsets
  localparam logic [3:0] FSL_STATUS_OFS   = 4'h0;
  localparam logic [3:0] FSL_TRIM_OFS     = 4'h4;
  localparam logic [3:0] FSL_IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] FSL_IRQ_MASK_OFS = 4'hc;

  // status register fields
  localparam int FSL_STAT_LATCH = 0;
  localparam int FSL_STAT_UV    = 1;
  localparam int FSL_STAT_CLK   = 2;
  localparam int FSL_STAT_PAR   = 3;
  localparam int FSL_STAT_REQ   = 4;
  localparam int FSL_STAT_RISE  = 5;

  // interrupt status and mask fields
  localparam int FSL_IRQ_W     = 4;
  localparam int FSL_IRQ_UV    = 0;
  localparam int FSL_IRQ_CLK   = 1;
  localparam int FSL_IRQ_PAR   = 2;
  localparam int FSL_IRQ_CLEAR = 3;

  // reset values
  localparam logic [15:0]        FSL_TRIM_RST     = 16'h0000;
  localparam logic [FSL_IRQ_W-1:0] FSL_IRQ_MASK_RST = 4'h0;
  localparam logic               FSL_LATCH_RST    = 1'b1;

  // axi responses
  localparam logic [1:0] FSL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FSL_RESP_SLVERR = 2'h2;

  // clock monitor timing
  localparam int FSL_CLK_MHZ       = 250;
  localparam int FSL_FAIL_MIN_KHZ  = 150;
  localparam int FSL_FAIL_MAX_KHZ  = 400;
  localparam int FSL_FAIL_KHZ      = 250;
  localparam int FSL_FAIL_CYCLES   = (FSL_CLK_MHZ * 1000) / FSL_FAIL_KHZ;

endpackage

// [core/fsl_mon_if.sv]
// conditioned pin levels and edges passed from monitor to latch core
`timescale 1ns/100ps
interface fsl_mon_if;
  logic req_level;
  logic req_rise;
  logic req_fall;
  logic uv_fault;
  logic clk_fault;

  modport mon
  (
    output req_level,
    output req_rise,
    output req_fall,
    output uv_fault,
    output clk_fault
  );

  modport core
  (
    input req_level,
    input req_rise,
    input req_fall,
    input uv_fault,
    input clk_fault
  );
endinterface

// [core/fsl_monitor.sv]
// pin synchronisers, self-test edge detect and oscillator monitor
`timescale 1ns/100ps
module fsl_monitor
  import fsl_pkg::*;
#(
  parameter int FAIL_CYCLES = FSL_FAIL_CYCLES
)
(
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // raw pins
  input  wire logic  selftest_request,
  input  wire logic  undervoltage_detect,
  input  wire logic  osc_sense,
  // conditioned outputs
  fsl_mon_if.mon     mon
);

  localparam int CW = $clog2(FAIL_CYCLES + 1);

  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic          req_d_reg;
  logic          osc_d_reg;
  logic [CW-1:0] period_reg;
  logic          slow_reg;
  wire           osc_edge;
  wire           period_end;

  // two-stage synchronisers for the three pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      req_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {osc_sense, undervoltage_detect, selftest_request};
      sync2_reg <= sync1_reg;
      req_d_reg <= sync2_reg[0];
      osc_d_reg <= sync2_reg[2];
    end
  end

  assign osc_edge   = sync2_reg[2] & ~osc_d_reg;
  assign period_end = (period_reg == CW'(FAIL_CYCLES));

  // count fast cycles between oscillator edges; too many means too slow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_reg <= '0;
      slow_reg   <= 1'b0;
    end
    else if (osc_edge)
    begin
      period_reg <= '0;
      slow_reg   <= 1'b0;
    end
    else if (period_end)
      slow_reg   <= 1'b1;
    else
      period_reg <= period_reg + 1'b1;
  end

  // edges of the self-test request and fault levels
  assign mon.req_level = sync2_reg[0];
  assign mon.req_rise  = sync2_reg[0] & ~req_d_reg;
  assign mon.req_fall  = ~sync2_reg[0] & req_d_reg;
  assign mon.uv_fault  = sync2_reg[1];
  assign mon.clk_fault = slow_reg;

endmodule

// [core/fsl_core.sv]
// fault status latch with axi4-lite registers and interrupt
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - status pin is the fault latch OR the self-test request level
// - undervoltage detect sets the fault latch
// - oscillator slower than the monitor minimum sets the fault latch
// - odd parity of the stored trim bits sets the fault latch
// - falling edge of self-test request clears the fault latch
// - no clear while any fault condition is still present
// - host raises self-test; device drives the stimulus while it is high
// - status untrusted until a self-test rising edge after power-up
// - clock monitor fails somewhere between 150 and 400 kHz
module fsl_core
  import fsl_pkg::*;
#(
  parameter int TRIM_W      = 16,
  parameter int FAIL_CYCLES = FSL_FAIL_CYCLES
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // device pins
  input  wire logic        selftest_request,
  input  wire logic        undervoltage_detect,
  input  wire logic        osc_sense,
  output logic             fault_status,
  output logic             selftest_drive,
  output logic             irq,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  fsl_mon_if mon_bus ();

  // state registers
  logic [TRIM_W-1:0]    trim_reg;
  logic                 latch_reg;
  logic                 latch_next;
  logic                 rise_seen_reg;
  logic                 status_reg;
  logic                 drive_reg;
  logic [FSL_IRQ_W-1:0] irq_stat_reg;
  logic [FSL_IRQ_W-1:0] irq_stat_next;
  logic [FSL_IRQ_W-1:0] irq_mask_reg;
  logic                 irq_reg;

  // bus registers
  logic                 awready_reg;
  logic                 wready_reg;
  logic [3:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 arready_reg;
  logic                 rvalid_reg;
  logic [31:0]          rdata_reg;
  logic [1:0]           rresp_reg;

  // decode wires
  wire                  parity_odd;
  wire                  fault_now;
  wire                  clear_event;
  wire                  aw_hs;
  wire                  w_hs;
  wire                  do_write;
  wire                  ar_hs;
  wire                  wr_trim;
  wire                  wr_stat;
  wire                  wr_mask;
  wire                  wr_hit;
  wire [31:0]           wmask;
  wire [31:0]           rd_word;
  wire                  rd_hit;
  wire [FSL_IRQ_W-1:0]  irq_set;
  wire [FSL_IRQ_W-1:0]  irq_clr;

  // register address decode used by the trim write decode; reads compare the address directly
  function automatic logic [1:0] fsl_decode(input logic [3:0] addr);
    logic [1:0] idx;
    idx = 2'h0;
    case (addr)
      FSL_STATUS_OFS:   idx = 2'h0;
      FSL_TRIM_OFS:     idx = 2'h1;
      FSL_IRQ_STAT_OFS: idx = 2'h2;
      FSL_IRQ_MASK_OFS: idx = 2'h3;
      default:          idx = 2'h0;
    endcase
    return idx;
  endfunction

  // pin conditioning and oscillator monitor
  fsl_monitor #(
    .FAIL_CYCLES (FAIL_CYCLES)
  ) u_monitor (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .selftest_request    (selftest_request),
    .undervoltage_detect (undervoltage_detect),
    .osc_sense           (osc_sense),
    .mon                 (mon_bus.mon)
  );

  // fault sources and latch next value
  assign parity_odd  = ^trim_reg;
  assign fault_now   = mon_bus.uv_fault | mon_bus.clk_fault | parity_odd;
  assign clear_event = mon_bus.req_fall & ~fault_now;
  assign latch_next  = fault_now ? 1'b1
                     : (mon_bus.req_fall ? 1'b0 : latch_reg);

  // fault latch, status pin and self-test drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_reg     <= FSL_LATCH_RST;
      rise_seen_reg <= 1'b0;
      status_reg    <= FSL_LATCH_RST;
      drive_reg     <= 1'b0;
    end
    else
    begin
      latch_reg     <= latch_next;
      rise_seen_reg <= rise_seen_reg | mon_bus.req_rise;
      status_reg    <= latch_next | mon_bus.req_level;
      drive_reg     <= mon_bus.req_level;
    end
  end

  // bus handshakes and write decode
  assign aw_hs    = s_axi_awvalid & awready_reg;
  assign w_hs     = s_axi_wvalid & wready_reg;
  assign ar_hs    = s_axi_arvalid & arready_reg;
  assign do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
  assign wr_hit   = (awaddr_reg[1:0] == 2'h0);
  assign wr_trim  = do_write & wr_hit
                  & (fsl_decode(awaddr_reg) == 2'h1)
                  & (awaddr_reg == FSL_TRIM_OFS);
  assign wr_stat  = do_write & (awaddr_reg == FSL_IRQ_STAT_OFS);
  assign wr_mask  = do_write & (awaddr_reg == FSL_IRQ_MASK_OFS);
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                     {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // interrupt events; a set in the clear cycle wins
  assign irq_set = {clear_event, parity_odd, mon_bus.clk_fault,
                    mon_bus.uv_fault};
  assign irq_clr = wr_stat ? (wdata_reg[FSL_IRQ_W-1:0]
                              & wmask[FSL_IRQ_W-1:0])
                           : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  // software registers and interrupt output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_reg     <= FSL_TRIM_RST[TRIM_W-1:0];
      irq_stat_reg <= '0;
      irq_mask_reg <= FSL_IRQ_MASK_RST;
      irq_reg      <= 1'b0;
    end
    else
    begin
      if (wr_trim)
        trim_reg <= (trim_reg & ~wmask[TRIM_W-1:0])
                  | (wdata_reg[TRIM_W-1:0] & wmask[TRIM_W-1:0]);
      if (wr_mask)
        irq_mask_reg <= (irq_mask_reg & ~wmask[FSL_IRQ_W-1:0])
                      | (wdata_reg[FSL_IRQ_W-1:0] & wmask[FSL_IRQ_W-1:0]);
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // write channel: take address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= FSL_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_reg <= 1'b0;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_trim | wr_stat | wr_mask) ? FSL_RESP_OKAY
                    : FSL_RESP_SLVERR;
      end
      if (s_axi_bready & bvalid_reg)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // read data selection
  assign rd_hit  = (s_axi_araddr[1:0] == 2'h0);
  assign rd_word =
      (s_axi_araddr == FSL_STATUS_OFS) ?
        {26'h0, rise_seen_reg, mon_bus.req_level, parity_odd,
         mon_bus.clk_fault, mon_bus.uv_fault, latch_reg}
    : (s_axi_araddr == FSL_TRIM_OFS) ?
        {{(32 - TRIM_W){1'b0}}, trim_reg}
    : (s_axi_araddr == FSL_IRQ_STAT_OFS) ?
        {28'h0, irq_stat_reg}
    : (s_axi_araddr == FSL_IRQ_MASK_OFS) ?
        {28'h0, irq_mask_reg}
    : 32'h0000_0000;

  // read channel: one read under way at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= FSL_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_hit ? FSL_RESP_OKAY : FSL_RESP_SLVERR;
    end
    else if (s_axi_rready & rvalid_reg)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign fault_status  = status_reg;
  assign selftest_drive = drive_reg;
  assign irq           = irq_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rvalid  = rvalid_reg;

endmodule

// [verif/fsl_host_model.sv]
// host model that pulses the self-test request pin
`timescale 1ns/100ps
module fsl_host_model
  import fsl_pkg::*;
#(
  parameter int HOLD = 40
)
(
  // clock
  input  wire logic aclk,
  // command from the bench
  input  wire logic go,
  // pin
  output logic      selftest_request
);
  // raise, hold, then drop the request; hold scaled for simulation
  initial
  begin
    selftest_request = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (go === 1'b1)
      begin
        selftest_request <= 1'b1;
        repeat (HOLD) @(posedge aclk);
        selftest_request <= 1'b0;
      end
    end
  end
endmodule

// [verif/fsl_core_properties.sv]
// concurrent checks on the fault status latch pins
`timescale 1ns/100ps
module fsl_core_properties
  import fsl_pkg::*;
#(
  parameter int FAIL_CYCLES = FSL_FAIL_CYCLES
)
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // pins
  input wire logic        selftest_request,
  input wire logic        undervoltage_detect,
  input wire logic        osc_sense,
  input wire logic        fault_status,
  input wire logic        selftest_drive,
  // write channels
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready
);
  logic        osc_reg;
  logic [11:0] idle_reg;

  // cycles since the last oscillator rising edge, saturating
  always_ff @(posedge aclk)
  begin
    osc_reg <= osc_sense;
    if (!aresetn || (osc_sense && !osc_reg))
      idle_reg <= 12'h000;
    else if (idle_reg != 12'hfff)
      idle_reg <= idle_reg + 12'h001;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // request held, supply low held, odd trim word written
  sequence req_held; selftest_request [*5]; endsequence
  sequence uv_held; undervoltage_detect [*6]; endsequence
  sequence trim_odd;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == FSL_TRIM_OFS &&
    s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hf &&
    ^s_axi_wdata[15:0];
  endsequence

  chk_req_forces_status: assert property (req_held |-> fault_status)
    else $error("status low while self-test held");
  chk_drive_rise_sync: assert property ($rose(selftest_request) |->
    (!selftest_drive) [*2] ##2 selftest_drive)
    else $error("stimulus rise timing wrong");
  chk_drive_fall: assert property ($fell(selftest_request) |->
    ##[3:4] !selftest_drive)
    else $error("stimulus not released");
  chk_uv_sets: assert property (undervoltage_detect |->
    ##[1:5] fault_status)
    else $error("undervoltage did not set status");
  chk_uv_no_clear: assert property (uv_held |-> fault_status)
    else $error("latch cleared during undervoltage");
  chk_fall_needs_idle: assert property ($fell(fault_status) |->
    !selftest_drive)
    else $error("status fell while self-test high");
  chk_clk_fault: assert property ((idle_reg > FAIL_CYCLES + 8) |->
    fault_status)
    else $error("stalled oscillator not flagged");
  chk_trim_parity: assert property (trim_odd |-> ##[1:8] fault_status)
    else $error("odd trim parity not flagged");
endmodule

bind fsl_core fsl_core_properties #(.FAIL_CYCLES(FAIL_CYCLES)) u_props
(
  .aclk(aclk), .aresetn(aresetn), .selftest_request(selftest_request),
  .undervoltage_detect(undervoltage_detect), .osc_sense(osc_sense),
  .fault_status(fault_status), .selftest_drive(selftest_drive),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready)
);

// [verif/fsl_core_tb_top.sv]
// self-checking bench for the fault status latch
`timescale 1ns/100ps
module fsl_core_tb_top
  import fsl_pkg::*;
;
  localparam int FAILC = 20;
  localparam int HOLD  = 40;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, osc_run = 1'b1;
  logic        undervoltage_detect = 1'b0, osc_sense = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        selftest_request, fault_status, selftest_drive, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] v;
  int          fails = 0, checked = 0;

  // clock and a free-running oscillator that can be stalled
  always #2 aclk = ~aclk;
  always @(posedge aclk) if (osc_run) osc_sense <= ~osc_sense;

  fsl_host_model #(.HOLD(HOLD)) u_host (.aclk, .go, .selftest_request);
  fsl_core #(.FAIL_CYCLES(FAILC)) DUT
  (
    .aclk, .aresetn, .selftest_request, .undervoltage_detect, .osc_sense,
    .fault_status, .selftest_drive, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t pin got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, m);
    checked++;
    if ((got & m) !== (exp & m))
    begin
      fails++;
      $display("BAD %0t word got %h want %h", $time, got, exp);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      aw = aw && (s_axi_awready !== 1'b1);
      w = w && (s_axi_wready !== 1'b1);
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chkw({30'h0, s_axi_bresp}, {30'h0, a == 4'h0 ? 2'h2 : 2'h0}, 32'h3);
  endtask

  // one read with masked data and response compare
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chkw(s_axi_rdata, e, m);
    chkw({30'h0, s_axi_rresp}, {30'h0, er}, 32'h3);
  endtask

  // self-test pulse through the host, checked mid-pulse
  task automatic pulse();
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (HOLD / 2) @(posedge aclk);
    chk1(fault_status, 1'b1);
    chk1(selftest_drive, 1'b1);
    repeat (HOLD / 2 + 10) @(posedge aclk);
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog, many times the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(29342));
    chk1(fault_status, 1'b1);
    chk1(irq, 1'b0);
    rd(FSL_TRIM_OFS, 32'h0, 32'hffff, FSL_RESP_OKAY);
    rd(FSL_IRQ_MASK_OFS, 32'h0, 32'hf, FSL_RESP_OKAY);
    rd(4'h2, 32'h0, 32'hffffffff, FSL_RESP_SLVERR);
    wr(FSL_STATUS_OFS, 32'h1);
    $display("test reset done");
    // clean pulse clears the latch and raises an event
    pulse();
    chk1(fault_status, 1'b0);
    rd(FSL_STATUS_OFS, 32'h20, 32'h21, FSL_RESP_OKAY);
    rd(FSL_IRQ_STAT_OFS, 32'h8, 32'h8, FSL_RESP_OKAY);
    chk1(irq, 1'b0);
    wr(FSL_IRQ_MASK_OFS, 32'h8);
    repeat (2) @(posedge aclk);
    chk1(irq, 1'b1);
    wr(FSL_IRQ_STAT_OFS, 32'h8);
    repeat (2) @(posedge aclk);
    chk1(irq, 1'b0);
    $display("test clear done");
    // low supply sets and pins the latch
    undervoltage_detect <= 1'b1;
    repeat ($urandom_range(12, 6)) @(posedge aclk);
    chk1(fault_status, 1'b1);
    pulse();
    chk1(fault_status, 1'b1);
    rd(FSL_IRQ_STAT_OFS, 32'h1, 32'h1, FSL_RESP_OKAY);
    undervoltage_detect <= 1'b0;
    pulse();
    chk1(fault_status, 1'b0);
    $display("test undervoltage done");
    // trim words, odd 8000 first, 0000 last, random between; odd parity must hold the latch
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 16'h8000 : (i == 5) ? 16'h0000 : 16'($urandom);
      wr(FSL_TRIM_OFS, {16'h0, v});
      rd(FSL_TRIM_OFS, {16'h0, v}, 32'hffff, FSL_RESP_OKAY);
      if (^v) chk1(fault_status, 1'b1);
      pulse();
      chk1(fault_status, ^v);
    end
    $display("test parity done");
    // stalled oscillator sets and pins the latch
    osc_run <= 1'b0;
    repeat (FAILC + 12) @(posedge aclk);
    chk1(fault_status, 1'b1);
    pulse();
    chk1(fault_status, 1'b1);
    rd(FSL_IRQ_STAT_OFS, 32'h2, 32'h2, FSL_RESP_OKAY);
    osc_run <= 1'b1;
    repeat (8) @(posedge aclk);
    pulse();
    chk1(fault_status, 1'b0);
    $display("test clock done");
    end_sim();
  end
endmodule
